// File: shared/flagirq_params.svh
/*
 * Register indices, field positions and reset values of the status
 * flag and interrupt block.
 * Assumes APB byte addresses equal four times the register index.
 */
`ifndef FLAGIRQ_PARAMS_SVH
`define FLAGIRQ_PARAMS_SVH

// ****************************************************
// register indices (byte address = index * 4)
// ****************************************************
`define IDX_STATUS_LO      6'h00
`define IDX_STATUS_HI      6'h01
`define IDX_CLEAR_LO       6'h02
`define IDX_CLEAR_HI       6'h03
`define IDX_IRQ_MASK       6'h04
`define IDX_SYS_CTRL_LO    6'h05

// ****************************************************
// reset values and latched-bit masks
// ****************************************************
`define RST_IRQ_MASK       8'h00
`define RST_READ_CLEAR_EN  1'b1
`define RST_CLEAR          8'h00
`define LO_LATCH_MASK      8'hfe
`define HI_LATCH_MASK      5'h1a

// ****************************************************
// field positions
// ****************************************************
`define POS_READ_CLEAR_EN  7
`define POS_LDO_OK         0
`define POS_TA             0
`define ST_RECT_OT         1
`define ST_CONV_OT         2
`define ST_RECT_REC        3
`define ST_CONV_REC        4
`define ST_EXT_HIGH        5
`define ST_EXT_LOW         6
`define ST_OVERCUR         7
`define ST_OVERPWR         3
`define ST_CLAMP           4
`define MSK_RECT           0
`define MSK_CONV           1
`define MSK_EXT_HIGH       2
`define MSK_EXT_LOW        3
`define MSK_OVERCUR        4
`define MSK_OVERPWR        5
`define MSK_CLAMP          6
`define MSK_TA             7

`endif

// File: shared/flagirq_pkg.sv
/*
 * Types shared by the status flag and interrupt block.
 * Assumes a 32-bit APB data path and 8-bit byte addresses.
 */
package flagirq_pkg;
	typedef logic [31:0] word_t;
	typedef logic [7:0]  byte_t;
	typedef logic [7:0]  paddr_t;
	// bus answer sequencing, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ANS  = 2'b10
	} apb_st_t;
endpackage

// File: shared/flag_if.sv
/*
 * Carrier between synchroniser, flag bank and the register logic.
 * Assumes all users run on the same core clock.
 */
`timescale 1ns/1ps
interface flag_if #(parameter int W = 8) ();
	logic [W-1:0] lvl;   // debounced pin level
	logic [W-1:0] rise;  // one-cycle rising event
	logic [W-1:0] chg;   // one-cycle change in either direction
	logic [W-1:0] clr;   // clear request pulse
	logic [W-1:0] flags; // latched flags
	modport src  (output lvl, output rise, output chg);
	modport bank (input rise, input clr, output flags);
endinterface

// File: src/pin_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter and edge pulses.
 * Assumes pins are asynchronous to the core clock.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 8 // number of pins
) (
	input  wire logic         clk,  // core clock
	input  wire logic         rst,  // synchronous reset, high
	input  wire logic [W-1:0] pins, // raw event pins
	flag_if.src               f     // level and edges out
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] lvl_ff;
	logic [W-1:0] agree;

	// shift chain; s1 feeds only s2 to keep metastability contained
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	assign agree = ~(s2_ff ^ s3_ff);

	// accepted level moves only where the last two stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			lvl_ff <= '0;
		end else begin
			lvl_ff <= (s3_ff & agree) | (lvl_ff & ~agree);
		end
	end

	assign f.lvl  = lvl_ff;
	assign f.chg  = agree & (s3_ff ^ lvl_ff);
	assign f.rise = agree & s3_ff & ~lvl_ff;
endmodule // pin_sync

// File: src/flag_bank.sv
/*
 * Bank of sticky event flags, set on a rising event, cleared on request.
 * Assumes clear and event pulses are on the core clock.
 */
`timescale 1ns/1ps
module flag_bank #(
	parameter int           W    = 8,  // number of flags
	parameter logic [W-1:0] MASK = '1  // positions that latch
) (
	input  wire logic clk, // core clock
	input  wire logic rst, // synchronous reset, high
	flag_if.bank      f    // events, clears, flags
);
	logic [W-1:0] flags_ff;

	// set wins over clear so an event in the clear cycle survives
	// held until cleared
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= ((flags_ff & ~f.clr) | f.rise) & MASK;
		end
	end

	assign f.flags = flags_ff;
endmodule // flag_bank

// File: src/status_flag_irq.sv
/*
 * Status flags, write-one clear, read clear and interrupt masking,
 * reached as an APB slave with one byte register per aligned word.
 * Assumes event pins are asynchronous levels, active high, and that the
 * APB master follows the standard setup and access phases.
 */
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "flagirq_params.svh"

// How it works
// - each flag clears alone on a written one; written zeros change nothing.
// - clear_lo bit n clears status_lo bit n for bits 1..7.
// - clear_hi bit n clears status_hi bit n for bits 1, 3 and 4.
// - ta_latch_clr clears only the hidden ta latch, never the ta_level bit.
// - ldo_supply_ok is a live level, never latched, never interrupting.
// - with read_clear_en set, reading a status register clears its latched flags.
// - clear_lo bits 1..7 match status_lo; bit 0 reserved; reset zero.
// - clear_hi bits 0,1,3,4 used; 2,5,6,7 reserved; reset zero.
// - irq_n is low while any flag with its enable bit set is set.
// - latched flags stay set until a clear write or enabled read clear.
// - irq_mask_reg bits 0..7 enable the eight interrupt sources; reset zero.
// - each temperature enable gates both overtemp and recovered flags.
// - with ta_irq_en set, both ta edges can raise the interrupt.
// - with read_clear_en clear, reads leave the flags unchanged.
// - status_lo bits hold ldo level then seven latched event flags.
// - status_hi holds ta_level, brownout, overpower, clamp; others read zero.
// - a flag captures the start edge of its event if the pin is held high for two or more clock edges.
// - a hidden latch records every ta_level change; cleared by ta_latch_clr or a status_hi read with read_clear_en set.
module status_flag_irq (
	input  wire logic                CORE_CLK,  // 10 MHz core clock
	input  wire logic                SRST,      // synchronous reset, high
	input  wire logic                PSEL,      // apb select
	input  wire logic                PENABLE,   // apb access phase
	input  wire logic                PWRITE,    // apb direction
	input  wire flagirq_pkg::paddr_t PADDR,     // apb byte address
	input  wire flagirq_pkg::word_t  PWDATA,    // apb write data
	output flagirq_pkg::word_t       PRDATA,    // apb read data
	output logic                     PREADY,    // apb ready
	output logic                     PSLVERR,   // apb error, unmapped
	input  wire logic [7:0]          LO_EVENTS, // ldo level and low events
	input  wire logic [4:0]          HI_EVENTS, // ta pin and high events
	output logic                     IRQ_N      // interrupt, low active
);
	import flagirq_pkg::*;

	// ****************************************************
	// signals
	// ****************************************************
	flag_if #(.W(8)) lo_f ();
	flag_if #(.W(5)) hi_f ();

	apb_st_t   st_ff;
	word_t     prdata_ff;
	logic      pready_ff;
	logic      pslverr_ff;
	logic      irq_n_ff;
	byte_t     mask_ff;
	logic      rc_en_ff;
	logic      ta_latch_ff;
	logic      done;
	logic      wr_done;
	logic      rd_done;
	byte_t     status_lo;
	byte_t     status_hi;
	logic      irq_src;
	logic      ta_clr;

	// ****************************************************
	// helpers
	// ****************************************************
	// byte address of a register index
	function automatic logic hit(paddr_t a, logic [5:0] idx);
		return a == {idx, 2'b00};
	endfunction

	// any flag gated through by the enable mask
	function automatic logic irq_due(byte_t lo, logic [4:0] hi, logic ta, byte_t m);
		logic r;
		r = 1'b0;
		r = r | (m[`MSK_RECT] & (lo[`ST_RECT_OT] | lo[`ST_RECT_REC]));
		r = r | (m[`MSK_CONV] & (lo[`ST_CONV_OT] | lo[`ST_CONV_REC]));
		r = r | (m[`MSK_EXT_HIGH] & lo[`ST_EXT_HIGH]);
		r = r | (m[`MSK_EXT_LOW] & lo[`ST_EXT_LOW]);
		r = r | (m[`MSK_OVERCUR] & lo[`ST_OVERCUR]);
		r = r | (m[`MSK_OVERPWR] & hi[`ST_OVERPWR]);
		r = r | (m[`MSK_CLAMP] & hi[`ST_CLAMP]);
		r = r | (m[`MSK_TA] & ta);
		return r;
	endfunction

	// ****************************************************
	// event capture
	// ****************************************************
	// a pin already high at release reads as a rising event a few edges later
	pin_sync #(.W(8)) u_lo_sync (
		.clk  (CORE_CLK),
		.rst  (SRST),
		.pins (LO_EVENTS),
		.f    (lo_f.src)
	);

	pin_sync #(.W(5)) u_hi_sync (
		.clk  (CORE_CLK),
		.rst  (SRST),
		.pins (HI_EVENTS),
		.f    (hi_f.src)
	);

	flag_bank #(.W(8), .MASK(`LO_LATCH_MASK)) u_lo_bank (
		.clk (CORE_CLK),
		.rst (SRST),
		.f   (lo_f.bank)
	);

	// brownout latches but has no enable bit, so it never reaches irq_n
	flag_bank #(.W(5), .MASK(`HI_LATCH_MASK)) u_hi_bank (
		.clk (CORE_CLK),
		.rst (SRST),
		.f   (hi_f.bank)
	);

	// ldo level plus latched low flags
	assign status_lo = {lo_f.flags[7:1], lo_f.lvl[`POS_LDO_OK]};
	// ta level live, reserved bits zero
	assign status_hi = {3'b000, hi_f.flags[4:1], hi_f.lvl[`POS_TA]};

	// ****************************************************
	// bus handshake
	// ****************************************************
	// completion needs our own ready, so an access phase seen alone
	// cannot trigger a write or a read clear by itself
	assign done    = PSEL & PENABLE & pready_ff;
	assign wr_done = done & PWRITE;
	assign rd_done = done & ~PWRITE;

	// answer one cycle into the access phase, read data captured then
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			st_ff      <= ST_IDLE;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end else begin
			unique case (st_ff)
				ST_IDLE: begin
					if (PSEL && PENABLE) begin
						st_ff      <= ST_ANS;
						pready_ff  <= 1'b1;
						pslverr_ff <= PADDR > {`IDX_SYS_CTRL_LO, 2'b00} || PADDR[1:0] != 2'b00;
						prdata_ff  <= '0;
						if (!PWRITE && hit(PADDR, `IDX_STATUS_LO)) begin
							prdata_ff[7:0] <= status_lo;
						end else if (!PWRITE && hit(PADDR, `IDX_STATUS_HI)) begin
							prdata_ff[7:0] <= status_hi;
						end else if (!PWRITE && hit(PADDR, `IDX_IRQ_MASK)) begin
							prdata_ff[7:0] <= mask_ff;
						end else if (!PWRITE && hit(PADDR, `IDX_SYS_CTRL_LO)) begin
							prdata_ff[`POS_READ_CLEAR_EN] <= rc_en_ff;
						end else if (!PWRITE) begin
							// write-only clear registers read as reset value
							prdata_ff[7:0] <= `RST_CLEAR;
						end
					end
				end
				ST_ANS: begin
					st_ff      <= ST_IDLE;
					pready_ff  <= 1'b0;
					pslverr_ff <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************
	// software registers
	// ****************************************************
	// enable mask, written whole
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			mask_ff <= `RST_IRQ_MASK;
		end else if (wr_done && hit(PADDR, `IDX_IRQ_MASK)) begin
			mask_ff <= PWDATA[7:0];
		end
	end

	// read clear enable; the other control bits live elsewhere
	// trade-off: only this bit is kept, the rest of sys_ctrl_lo reads zero
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			rc_en_ff <= `RST_READ_CLEAR_EN;
		end else if (wr_done && hit(PADDR, `IDX_SYS_CTRL_LO)) begin
			rc_en_ff <= PWDATA[`POS_READ_CLEAR_EN];
		end
	end

	// ****************************************************
	// clear paths
	// ****************************************************
	// read clear uses the captured byte, not the live flags: an event landing
	// between capture and completion survives to the next read
	// ones clear, zeros keep; reserved bit 0 masked
	// low clear hits low flags; read clear takes only reported bits
	assign lo_f.clr = ({8{wr_done && hit(PADDR, `IDX_CLEAR_LO)}} & PWDATA[7:0]
		| {8{rd_done && rc_en_ff && hit(PADDR, `IDX_STATUS_LO)}} & prdata_ff[7:0])
		& `LO_LATCH_MASK;
	// high clear hits high flags; reserved bits masked
	assign hi_f.clr = ({5{wr_done && hit(PADDR, `IDX_CLEAR_HI)}} & PWDATA[4:0]
		| {5{rd_done && rc_en_ff && hit(PADDR, `IDX_STATUS_HI)}} & prdata_ff[4:0])
		& `HI_LATCH_MASK;
	// ta clear bit reaches the hidden latch only
	assign ta_clr = (wr_done && hit(PADDR, `IDX_CLEAR_HI) && PWDATA[`POS_TA])
		|| (rd_done && rc_en_ff && hit(PADDR, `IDX_STATUS_HI));

	// hidden ta latch, both edges, change wins over clear
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			ta_latch_ff <= 1'b0;
		end else begin
			ta_latch_ff <= hi_f.chg[`POS_TA] | (ta_latch_ff & ~ta_clr);
		end
	end

	// ****************************************************
	// interrupt output
	// ****************************************************
	// ldo level and brownout never reach the line
	assign irq_src = irq_due(lo_f.flags, hi_f.flags, ta_latch_ff, mask_ff);

	// registered so the line cannot glitch while flags and mask settle
	// low while anything enabled is pending; high once none
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			irq_n_ff <= 1'b1;
		end else begin
			irq_n_ff <= ~irq_src;
		end
	end

	assign PRDATA  = prdata_ff;
	assign PREADY  = pready_ff;
	assign PSLVERR = pslverr_ff;
	assign IRQ_N   = irq_n_ff;

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SRST);

	// the steps of a transfer, shared by several properties
	sequence s_access;
		PSEL && PENABLE && !pready_ff;
	endsequence
	sequence s_read_lo;
		rd_done && hit(PADDR, `IDX_STATUS_LO);
	endsequence
	sequence s_clear_lo;
		wr_done && hit(PADDR, `IDX_CLEAR_LO);
	endsequence
	sequence s_read_hi;
		rd_done && hit(PADDR, `IDX_STATUS_HI);
	endsequence

	// one wait state, then ready for a single cycle
	a_apb_answer: assert property (s_access |=> PREADY ##1 !PREADY)
		else $error("apb answer not one cycle into access");
	a_clear_lo_ones: assert property (
		s_clear_lo |=> (lo_f.flags & $past(PWDATA[7:0]) & ~$past(lo_f.rise)) == 8'h00)
		else $error("low clear left a written flag set");
	a_clear_zero_keep: assert property (
		s_clear_lo |=> (lo_f.flags & ~$past(PWDATA[7:0]))
			== (($past(lo_f.flags) | $past(lo_f.rise)) & ~$past(PWDATA[7:0]) & 8'hfe))
		else $error("written zero disturbed a flag");
	a_clear_hi_ones: assert property (
		wr_done && hit(PADDR, `IDX_CLEAR_HI)
		|=> (hi_f.flags & $past(PWDATA[4:0]) & ~$past(hi_f.rise)) == 5'h00)
		else $error("high clear left a written flag set");
	a_ta_clear_only: assert property (
		wr_done && hit(PADDR, `IDX_CLEAR_HI) && PWDATA[0] && !hi_f.chg[0]
		|=> !ta_latch_ff && status_hi[0] == $past(hi_f.lvl[0] ^ hi_f.chg[0]))
		else $error("ta clear misbehaved");
	a_read_clear_lo: assert property (
		(s_read_lo ##0 rc_en_ff)
		|=> (lo_f.flags & $past(prdata_ff[7:0]) & ~$past(lo_f.rise)) == 8'h00)
		else $error("read clear left a reported flag");
	a_read_keep: assert property (
		(s_read_lo ##0 !rc_en_ff)
		|=> lo_f.flags == ($past(lo_f.flags | lo_f.rise) & 8'hfe))
		else $error("read changed flags with read clear off");
	a_irq_low: assert property (
		irq_src |=> !IRQ_N)
		else $error("enabled flag did not pull irq low");
	a_irq_release: assert property (
		!irq_src |=> IRQ_N)
		else $error("irq held low with nothing enabled");
	a_ldo_quiet: assert property (
		$changed(lo_f.lvl[0]) && !irq_src ##1 !irq_src |=> IRQ_N && !lo_f.flags[0])
		else $error("ldo level raised an interrupt");
	a_flag_hold: assert property (
		1'b1 |=> (lo_f.flags & $past(lo_f.flags & ~lo_f.clr)) == $past(lo_f.flags & ~lo_f.clr))
		else $error("flag dropped without clear");
	a_set_wins: assert property (
		(lo_f.rise & lo_f.clr & 8'hfe) != 8'h00
		|=> (lo_f.flags & $past(lo_f.rise & lo_f.clr)) == $past(lo_f.rise & lo_f.clr & 8'hfe))
		else $error("event lost in clear cycle");
	a_ta_edge: assert property (
		hi_f.chg[0] |=> ta_latch_ff ##1 (!IRQ_N || !$past(mask_ff[7])))
		else $error("ta change not latched");

	// ****************************************************
	// assertions on read data and capture
	// ****************************************************
	a_read_clear_hi: assert property (
		(s_read_hi ##0 rc_en_ff)
		|=> (hi_f.flags & $past(prdata_ff[4:0]) & ~$past(hi_f.rise)) == 5'h00)
		else $error("high read clear left a reported flag");
	a_ta_read_clear: assert property (
		(s_read_hi ##0 rc_en_ff ##0 !hi_f.chg[0]) |=> !ta_latch_ff)
		else $error("status_hi read left the ta latch set");
	a_hi_reserved: assert property (
		s_read_hi |-> PRDATA[7:5] == 3'b000 && PRDATA[2] == 1'b0)
		else $error("reserved status_hi bit read as one");
	a_mask_write: assert property (
		wr_done && hit(PADDR, `IDX_IRQ_MASK) |=> mask_ff == $past(PWDATA[7:0]))
		else $error("mask write did not land");
	a_flag_capture: assert property (
		(lo_f.rise & 8'hfe) != 8'h00
		|=> (lo_f.flags & $past(lo_f.rise & 8'hfe)) == $past(lo_f.rise & 8'hfe))
		else $error("rising low event not captured");
	a_hi_capture: assert property (
		(hi_f.rise & 5'h1a) != 5'h00
		|=> (hi_f.flags & $past(hi_f.rise & 5'h1a)) == $past(hi_f.rise & 5'h1a))
		else $error("rising high event not captured");
	a_ta_set_wins: assert property (
		hi_f.chg[0] && ta_clr |=> ta_latch_ff)
		else $error("ta change lost in clear cycle");
endmodule // status_flag_irq

// File: test/event_pins.sv
/*
 * Far-side model: the sensing circuits that raise the event pins.
 * Assumes the bench asks for pin levels just after a rising edge.
 */
`timescale 1ns/1ps
module event_pins (
	input  wire logic       clk,     // core clock
	input  wire logic [7:0] lo_req,  // wanted low pin levels
	input  wire logic [4:0] hi_req,  // wanted high pin levels
	output logic      [7:0] lo_pins, // low event pins
	output logic      [4:0] hi_pins  // high event pins
);
	// sensors move on the clock so pins change only at a rising edge, sampled one edge later
	always_ff @(posedge clk) begin
		lo_pins <= lo_req;
		hi_pins <= hi_req;
	end
endmodule // event_pins

// File: test/test_status_flag_irq.sv
/*
 * Self-checking bench: APB read and write calls with expected values.
 * Assumes an APB slave that raises ready within twenty cycles of access.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_status_flag_irq;
	import flagirq_pkg::*;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       psel = 1'b0;
	logic       penable = 1'b0;
	logic       pwrite = 1'b0;
	paddr_t     paddr = 8'h00;
	word_t      pwdata = 32'h0;
	word_t      prdata;
	logic       pready;
	logic       pslverr;
	logic       irq_n;
	logic [7:0] lo_req = 8'h01;
	logic [4:0] hi_req = 5'h00;
	logic [7:0] lo_pins;
	logic [4:0] hi_pins;
	int         failures = 0;
	int         check_count = 0;
	byte_t      q;
	logic       e;
	logic [23:0] upper_q;
	byte_t      tm[11] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
		8'h40, 8'h80, 8'hff};
	byte_t      tl[11] = '{8'h02, 8'h08, 8'h04, 8'h10, 8'h20, 8'h40, 8'h80, 8'h00,
		8'h00, 8'h00, 8'h00};
	logic [4:0] th[11] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h08,
		5'h10, 5'h01, 5'h02};
	byte_t      ch[3] = '{8'h02, 8'h08, 8'h10};
	byte_t      he[3] = '{8'h18, 8'h10, 8'h00};
	byte_t      ex;

	always #50 clk = ~clk;

	event_pins pins_u (.clk(clk), .lo_req(lo_req), .hi_req(hi_req), .lo_pins(lo_pins),
		.hi_pins(hi_pins));

	status_flag_irq dut_u (.CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .LO_EVENTS(lo_pins), .HI_EVENTS(hi_pins),
		.IRQ_N(irq_n));

	// ****************************************************
	// closing report and bus tasks
	// ****************************************************
	task close_out();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one transfer; an idle cycle always parts two calls
	task apb(input logic w, input paddr_t a, input byte_t d, output byte_t rq,
		output logic re);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// ready, data and error are all taken at the completing rising edge
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			close_out();
		end
		rq = prdata[7:0];
		upper_q = prdata[31:8];
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input paddr_t a, input byte_t d);
		apb(1'b1, a, d, q, e);
	endtask

	task rd(input paddr_t a, input byte_t x, input string nm);
		apb(1'b0, a, 8'h00, q, e);
		`CHK(nm, x, q)
		`CHK("rd_upper", 24'h000000, upper_q)
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task chk_irq(input logic x, input string nm);
		@(negedge clk);
		`CHK(nm, x, irq_n)
		@(posedge clk);
	endtask

	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(8'h10, 8'h00, "mask_rst");
		rd(8'h14, 8'h80, "rdclr_rst");
		rd(8'h08, 8'h00, "clr_lo_rst");
		rd(8'h0c, 8'h00, "clr_hi_rst");
		apb(1'b0, 8'h18, 8'h00, q, e);
		`CHK("unmapped", 1'b1, e)
		apb(1'b0, 8'h05, 8'h00, q, e);
		`CHK("misaligned", 1'b1, e)
		// flags latch and survive reads with read clear off
		wr(8'h14, 8'h00);
		lo_req <= 8'hff;
		hi_req <= 5'h1f;
		cyc(6);
		rd(8'h00, 8'hff, "status_lo");
		rd(8'h01 << 2, 8'h1b, "status_hi");
		rd(8'h00, 8'hff, "lo_noclr");
		chk_irq(1'b1, "irq_mask0");
		lo_req <= 8'h01;
		hi_req <= 5'h00;
		cyc(6);
		rd(8'h00, 8'hff, "lo_sticky");
		rd(8'h04, 8'h1a, "hi_sticky");
		// one flag at a time, reserved bits written as zero
		ex = 8'hff;
		for (int i = 1; i < 8; i++) begin
			wr(8'h08, 8'h01 << i);
			ex = ex & ~(8'h01 << i);
			rd(8'h00, ex, "clr_lo_bit");
		end
		// an event landing on its own clear edge stays latched
		lo_req <= 8'h03;
		cyc(1);
		wr(8'h08, 8'h02);
		rd(8'h00, 8'h03, "set_wins");
		lo_req <= 8'h01;
		wr(8'h08, 8'h02);
		for (int i = 0; i < 3; i++) begin
			wr(8'h0c, ch[i]);
			rd(8'h04, he[i], "clr_hi_bit");
		end
		hi_req <= 5'h01;
		cyc(6);
		wr(8'h0c, 8'h01);
		rd(8'h04, 8'h01, "ta_level_kept");
		hi_req <= 5'h00;
		cyc(6);
		// each enable bit against the flags it gates
		for (int i = 0; i < 11; i++) begin
			wr(8'h0c, 8'h1b);
			wr(8'h10, 8'h00);
			lo_req <= 8'h01 | tl[i];
			hi_req <= th[i];
			cyc(6);
			lo_req <= 8'h01;
			hi_req <= 5'h00;
			cyc(6);
			chk_irq(1'b1, "irq_masked");
			wr(8'h10, tm[i]);
			cyc(1);
			chk_irq(i == 10, "irq_enabled");
			wr(8'h08, 8'hfe);
			wr(8'h0c, 8'h1b);
			cyc(1);
			chk_irq(1'b1, "irq_released");
		end
		rd(8'h10, 8'hff, "mask_rw");
		// read clear on: both edges of the ta input
		wr(8'h10, 8'h80);
		wr(8'h14, 8'h80);
		lo_req <= 8'hff;
		hi_req <= 5'h1b;
		cyc(6);
		chk_irq(1'b0, "ta_rise_irq");
		rd(8'h00, 8'hff, "lo_rdclr1");
		rd(8'h00, 8'h01, "lo_rdclr2");
		rd(8'h04, 8'h1b, "hi_rdclr1");
		rd(8'h04, 8'h01, "hi_rdclr2");
		cyc(1);
		chk_irq(1'b1, "ta_latch_rd");
		hi_req <= 5'h00;
		cyc(6);
		chk_irq(1'b0, "ta_fall_irq");
		// reset in mid-run: line released, registers back to reset values
		srst <= 1'b1;
		cyc(2);
		srst <= 1'b0;
		chk_irq(1'b1, "irq_rst");
		rd(8'h10, 8'h00, "mask_rst2");
		rd(8'h14, 8'h80, "rdclr_rst2");
		close_out();
	end
endmodule // test_status_flag_irq
